// File: shared/tag_ram_pkg.sv
// package: pin timing constants and command codes for the tag ram controller
package tag_ram_pkg;
  localparam int unsigned clk_period_ns = 50;
  // pin timings in nanoseconds, slowest grade; the clear duty limit in percent
  localparam int unsigned min_write_pulse_ns = 14;
  localparam int unsigned write_turnoff_delay_ns = 9;
  localparam int unsigned data_valid_before_write_end_ns = 12;
  localparam int unsigned min_clear_pulse_ns = 25;
  localparam int unsigned addr_setup_ns = 0;
  localparam int unsigned clear_to_write_ns = 5;
  localparam int unsigned match_valid_ns = 25;
  localparam int unsigned clear_duty_pct = 10;
  // least times round up, at least one cycle
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + clk_period_ns - 1) / clk_period_ns;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned wpulse_oe_ns =
    (min_write_pulse_ns > write_turnoff_delay_ns + data_valid_before_write_end_ns) ?
    min_write_pulse_ns : (write_turnoff_delay_ns + data_valid_before_write_end_ns);
  localparam int unsigned write_cyc = cyc_up(wpulse_oe_ns);
  localparam int unsigned turnoff_cyc = cyc_up(write_turnoff_delay_ns);
  localparam int unsigned clear_cyc = cyc_up(min_clear_pulse_ns);
  localparam int unsigned clear_recover_cyc = cyc_up(clear_to_write_ns);
  localparam int unsigned match_cyc = cyc_up(match_valid_ns);
  localparam int unsigned setup_cyc = cyc_up(addr_setup_ns);
  // idle after a clear keeps the clear pin low at most a tenth of the time
  localparam int unsigned clear_idle_cyc = clear_cyc * (100 / clear_duty_pct - 1);
  localparam int unsigned cnt_w = 8;
  // commands on the user side
  localparam logic [1:0] cmd_match = 2'h0;
  localparam logic [1:0] cmd_write = 2'h1;
  localparam logic [1:0] cmd_read = 2'h2;
  localparam logic [1:0] cmd_clear = 2'h3;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_setup = 3'b001,
    st_strobe = 3'b011,
    st_sample = 3'b010,
    st_hold = 3'b110,
    st_recover = 3'b111
  } ctl_state_e;
endpackage

// File: shared/pulse_timer_if.sv
// interface: load and done between the sequencer and its interval timer
interface pulse_timer_if;
  logic load;
  logic [7:0] count;
  logic done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// File: src/pulse_timer.sv
// interval timer: counts down a loaded number of cycles
module pulse_timer
  import tag_ram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  pulse_timer_if.timer tmr
);
  logic [cnt_w-1:0] left_r;
  logic [cnt_w-1:0] left_nxt;
  wire logic busy = (left_r != '0);
  // load wins over counting so back to back intervals start clean
  assign left_nxt = tmr.load ? tmr.count : (busy ? left_r - 8'h01 : left_r);
  assign tmr.done = (left_r == 8'h01);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      left_r <= '0;
    end else begin
      left_r <= left_nxt;
    end
  end
endmodule

// File: src/tag_ram_ctrl.sv
// controller that drives the tag compare ram through its pins
//
// Summary of operation
// - write strobe stays high whenever the index changes
// - write pulse with output drive low is max of pulse and turnoff plus data
// - controller never drives data while device drivers may still be on
// - index and data inputs are never left floating while hit is used
// - clear pin low at most a tenth of the time
//
// limits: one command in flight at a time; every interval is a whole number of clock
// periods, so at this slow clock the pin timings are met with a wide margin
module tag_ram_ctrl
  import tag_ram_pkg::*;
#(
  parameter int unsigned index_w = 12,
  parameter int unsigned data_w = 4
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [index_w-1:0] cmd_index,
  input wire logic [data_w-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [data_w-1:0] rsp_data,
  output logic tags_cleared,
  output logic [index_w-1:0] tag_index,
  output logic [data_w-1:0] tag_data_out,
  output logic tag_data_oe_n,
  input wire logic [data_w-1:0] tag_data_in,
  input wire logic hit_in,
  output logic write_strobe_n,
  output logic output_drive_n,
  output logic array_clear_n
);
  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (index_w != 12 || data_w != 4) begin : g_bad_size
    $error("tag ram controller serves only a 4096 by 4 array");
  end
  // every interval is loaded into an 8 bit down counter
  if (clear_idle_cyc > 255 || write_cyc > 255 || match_cyc > 255 || clear_cyc > 255) begin : g_bad_cnt
    $error("timing counts exceed timer width");
  end
  // the idle tail after a clear is what keeps the clear pin under its duty limit
  if (clear_idle_cyc * clear_duty_pct < clear_cyc * (100 - clear_duty_pct)) begin : g_bad_duty
    $error("clear idle too short for the duty limit");
  end

  // ************************************************************
  // state and pin registers
  // ************************************************************
  ctl_state_e state_r, state_nxt;
  logic [1:0] op_r;
  logic cleared_r;
  // one shared timer: only one interval runs at any time
  pulse_timer_if tmr ();

  pulse_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .tmr(tmr)
  );

  // ************************************************************
  // decode
  // ************************************************************
  // the startup clear is forced before any user command is taken
  wire logic take = (state_r == st_idle) && cmd_valid && cleared_r;
  wire logic take_clr = (state_r == st_idle) && !cleared_r;
  wire logic [1:0] take_op = cleared_r ? cmd_op : cmd_clear;
  wire logic is_wr = (op_r == cmd_write);
  wire logic is_rd = (op_r == cmd_read);
  wire logic is_clr = (op_r == cmd_clear);
  // op of the command in flight, the new one already on the edge that takes it
  wire logic [1:0] op_sel = (take || take_clr) ? take_op : op_r;
  // strobe length per operation
  wire logic [7:0] strobe_len = is_clr ? 8'(clear_cyc) : (is_wr ? 8'(write_cyc) : 8'(match_cyc));
  wire logic [7:0] recover_len = is_clr ? 8'(clear_idle_cyc) : 8'(clear_recover_cyc);

  // ************************************************************
  // sequencer
  // ************************************************************

  // sequence: setup, strobe, sample, hold, recover
  // defaults: no timer load, state stays
  always_comb begin
    state_nxt = state_r;
    tmr.load = 1'b0;
    tmr.count = 8'h00;
    case (state_r)
      st_idle: begin
        if (take || take_clr) begin
          state_nxt = st_setup;
          tmr.load = 1'b1;
          tmr.count = 8'(setup_cyc);
        end
      end
      // index and data settle for one interval before any strobe falls
      st_setup: begin
        if (tmr.done) begin
          state_nxt = st_strobe;
          tmr.load = 1'b1;
          tmr.count = strobe_len;
        end
      end
      st_strobe: begin
        if (tmr.done) begin
          state_nxt = st_sample;
        end
      end
      // hit and read data are taken on the edge that leaves this state
      st_sample: begin
        state_nxt = st_hold;
        tmr.load = 1'b1;
        tmr.count = 8'(turnoff_cyc);
      end
      // hold gives the device drivers their turnoff time after a read
      st_hold: begin
        if (tmr.done) begin
          state_nxt = st_recover;
          tmr.load = 1'b1;
          tmr.count = recover_len;
        end
      end
      // recover spaces commands; after a clear it keeps the duty low
      st_recover: begin
        if (tmr.done) begin
          state_nxt = st_idle;
        end
      end
      default: state_nxt = st_idle;
    endcase
  end

  // ************************************************************
  // pin drive
  // ************************************************************

  // pin levels for next cycle; index moves only in idle with strobe high
  wire logic in_strobe_nxt = (state_nxt == st_strobe);
  wire logic we_n_nxt = !(in_strobe_nxt && is_wr);
  wire logic clr_n_nxt = !(in_strobe_nxt && is_clr);
  // output drive low only for reads; high keeps device compare mode
  wire logic oe_n_nxt = !((state_nxt == st_strobe || state_nxt == st_sample) && is_rd);
  // our data drivers on for match and write, off around reads and clears
  wire logic drv_nxt = (op_sel != cmd_read) && (op_sel != cmd_clear) && (state_nxt != st_idle);

  // state and the op of the command in flight
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= st_idle;
      op_r <= cmd_match;
    end else begin
      state_r <= state_nxt;
      if (take || take_clr) begin
        op_r <= take_op;
      end
    end
  end

  // pin flops; output drive and clear idle high, data floats
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_strobe_n <= 1'b1;
      array_clear_n <= 1'b1;
      output_drive_n <= 1'b1;
      tag_data_oe_n <= 1'b1;
      tag_index <= '0;
      tag_data_out <= '0;
    end else begin
      write_strobe_n <= we_n_nxt;
      array_clear_n <= clr_n_nxt;
      output_drive_n <= oe_n_nxt;
      tag_data_oe_n <= !drv_nxt;
      // index and data move only on the taking edge, while every strobe is high
      tag_index <= (take || take_clr) ? cmd_index : tag_index;
      tag_data_out <= (take || take_clr) ? cmd_data : tag_data_out;
    end
  end

  // ************************************************************
  // response
  // ************************************************************

  // answer in sample: hit only trusted for match; hit ignored in write, read, clear
  wire logic sample = (state_r == st_sample);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_data <= '0;
      cleared_r <= 1'b0;
      tags_cleared <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      rsp_valid <= sample;
      rsp_hit <= sample ? (hit_in && (op_r == cmd_match)) : rsp_hit;
      // read data latched; data after a clear is undefined so not returned
      rsp_data <= (sample && is_rd) ? tag_data_in : rsp_data;
      cleared_r <= cleared_r || (sample && is_clr);
      tags_cleared <= cleared_r || (sample && is_clr);
      cmd_ready <= (state_nxt == st_idle) && (cleared_r || (sample && is_clr));
    end
  end
endmodule

// File: test/tag_ram_model.sv
// behavioural model of the 4k x 4 tag compare ram seen from its pins
module tag_ram_model (
  input wire logic [11:0] tag_index,
  input wire logic [3:0] bus,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic array_clear_n,
  output logic hit,
  output logic [3:0] q,
  output logic q_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // contents start unknown, so a missing startup clear shows as x hits
  logic [3:0] mem [4096];
  // clear wins over write; write ignores the output drive pin
  always @(array_clear_n, write_strobe_n, tag_index, bus) begin
    if (!array_clear_n) foreach (mem[i]) mem[i] = 4'h0;
    else if (!write_strobe_n) mem[tag_index] = bus;
  end
  // comparator runs in every cycle; level during clear is arbitrary
  assign hit = array_clear_n ? (mem[tag_index] == bus) : 1'b1;
  // drivers on for read, or for clear with output drive, junk data then
  assign q_oe_n = output_drive_n | (array_clear_n & ~write_strobe_n);
  assign q = array_clear_n ? mem[tag_index] : 4'ha;
endmodule

// File: test/tag_ram_ctrl_props.sv
// checker: pin timing and handshake of the tag ram controller
module tag_ram_ctrl_props
  import tag_ram_pkg::*;
#(
  parameter int unsigned index_w = 12,
  parameter int unsigned data_w = 4
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [data_w-1:0] rsp_data,
  input wire logic tags_cleared,
  input wire logic [index_w-1:0] tag_index,
  input wire logic tag_data_oe_n,
  input wire logic [data_w-1:0] tag_data_in,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic array_clear_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****
  // pin and handshake rules
  // ****
  chk_index_hold: assert property (!write_strobe_n |-> $stable(tag_index))
    else $error("index moved under write strobe");
  chk_write_pulse: assert property ($fell(write_strobe_n) |-> !tag_data_oe_n && !$past(tag_data_oe_n)
    ##1 write_strobe_n && !tag_data_oe_n) else $error("write pulse shape wrong");
  chk_no_contend: assert property (!tag_data_oe_n |-> output_drive_n && $past(output_drive_n))
    else $error("data driven against device");
  chk_clear_idle: assert property ($fell(array_clear_n) |=> array_clear_n[*8] ##1 array_clear_n)
    else $error("clear duty too high");
  chk_clear_first: assert property (!tags_cleared |-> !cmd_ready && write_strobe_n)
    else $error("ready before startup clear");
  chk_read_data: assert property (rsp_valid && !$past(output_drive_n) |-> rsp_data == $past(tag_data_in))
    else $error("read data not captured");
  chk_take_rsp: assert property (cmd_valid && cmd_ready |=> !cmd_ready ##2 !rsp_valid ##1 rsp_valid)
    else $error("response latency wrong");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
  cover property (rsp_valid && rsp_hit);
  cover property ($fell(write_strobe_n));
  cover property ($fell(output_drive_n));
  cover property ($fell(array_clear_n));
endmodule
bind tag_ram_ctrl tag_ram_ctrl_props #(.index_w(index_w), .data_w(data_w)) u_props (.*);

// File: test/tag_ram_ctrl_tb.sv
// testbench: controller against the ram model with a reference memory
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module tag_ram_ctrl_tb;
  import tag_ram_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, cmd_valid = 0, rsp_valid, rsp_hit, cmd_ready, tags_cleared;
  logic [1:0] cmd_op = 0;
  logic [11:0] cmd_index = 0, tag_index;
  logic [3:0] cmd_data = 0, rsp_data, tag_data_out, bus, q;
  logic tag_data_oe_n, hit, q_oe_n, write_strobe_n, output_drive_n, array_clear_n;
  logic [3:0] ref_mem [4096];
  logic [31:0] seed = 32'h1e84_f12c;
  int failures = 0, checks_done = 0;
  // undriven lines show the inverse of our last data, not a kind zero
  assign bus = !tag_data_oe_n ? tag_data_out : !q_oe_n ? q : ~tag_data_out;
  tag_ram_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_hit(rsp_hit), .rsp_data(rsp_data), .tags_cleared(tags_cleared), .tag_index(tag_index),
    .tag_data_out(tag_data_out), .tag_data_oe_n(tag_data_oe_n), .tag_data_in(bus), .hit_in(hit),
    .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n), .array_clear_n(array_clear_n));
  tag_ram_model u_ram (.tag_index(tag_index), .bus(bus), .write_strobe_n(write_strobe_n),
    .output_drive_n(output_drive_n), .array_clear_n(array_clear_n), .hit(hit), .q(q), .q_oe_n(q_oe_n));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one command: hold valid until ready is sampled, then await the response
  task automatic cmd(input logic [1:0] op, input logic [11:0] ix, input logic [3:0] d);
    int n;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_index <= ix;
    cmd_data <= d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (cmd_ready !== 1'b1 && n < 60);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 20);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_hit", (op == cmd_match) && (ref_mem[ix] === d), rsp_hit)
    if (op == cmd_read) `CHK("rsp_data", ref_mem[ix], rsp_data)
    if (op == cmd_write) ref_mem[ix] = d;
    if (op == cmd_clear) foreach (ref_mem[i]) ref_mem[i] = 4'h0;
  endtask
  // watchdog: a few hundred cycles are expected, allow well over that
  initial begin
    #(4000 * 50);
    failures++;
    results();
  end
  initial begin
    logic [1:0] op;
    logic [11:0] ix;
    foreach (ref_mem[i]) ref_mem[i] = 4'h0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    cmd(cmd_match, 12'h000, 4'h0);
    cmd(cmd_write, 12'hfff, 4'hf);
    cmd(cmd_match, 12'hfff, 4'hf);
    cmd(cmd_match, 12'hfff, 4'he);
    cmd(cmd_read, 12'hfff, 4'h0);
    `CHK("tags_cleared", 1'b1, tags_cleared)
    $display("boundary test done");
    for (int k = 0; k < 60; k++) begin
      op = 2'(xs());
      if (op == cmd_clear && xs() % 4 != 0) op = cmd_read;
      ix = 12'(xs()) & 12'hf07;
      cmd(op, ix, xs() % 2 ? ref_mem[ix] : 4'(xs()));
    end
    $display("random test done");
    results();
  end
endmodule
